// ===== dv/analog_side_model.sv
// Partner: analog front end finishing one reading for each conversion clock tick
`timescale 1ns/1ps
module analog_side_model (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic adc_tick,
  output logic      conv_done,
  output logic [11:0] temp_internal,
  output logic [11:0] temp_external
);
  // Reading lands a cycle after its tick; temperatures drift so tracking is never stale
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      conv_done     <= 1'b0;
      temp_internal <= 12'h000;
      temp_external <= 12'hFFF;
    end else begin
      conv_done     <= adc_tick;
      temp_internal <= temp_internal + 12'h001;
      temp_external <= temp_external - 12'h001;
    end
  end
endmodule // analog_side_model

// ===== dv/monitor_and_dac_update_control_bench.sv
// Testbench: register traffic and load pin against a behavioural model
`timescale 1ns/1ps
module monitor_and_dac_update_control_bench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic spi_select_req = 1'b0;
  logic load_outputs_strobe_n = 1'b1;
  monitor_dac_pkg::reg_req_t reg_req = '0;
  monitor_dac_pkg::channel_t channel, exp_ch;
  monitor_dac_pkg::analog_ctl_t analog_ctl;
  logic conv_done, cal_done, measuring, result_valid, adc_tick, spi_locked, dac_out_en;
  logic [11:0] temp_internal, temp_external;
  logic [7:0] reg_rdata;
  logic [47:0] dac_code_out;
  monitor_dac_pkg::channel_t ch_q [$];
  int failures = 0;
  int compares = 0;
  int live [8];
  int pend [8];
  int i, n, v;

  always #25 core_clk = ~core_clk;

  monitor_and_dac_update_control uut (.core_clk(core_clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .spi_select_req(spi_select_req),
    .load_outputs_strobe_n(load_outputs_strobe_n), .conv_done(conv_done),
    .temp_internal(temp_internal), .temp_external(temp_external), .spi_locked(spi_locked),
    .cal_done(cal_done), .measuring(measuring), .channel(channel),
    .result_valid(result_valid), .adc_tick(adc_tick), .analog_ctl(analog_ctl),
    .dac_out_en(dac_out_en), .dac_code_out(dac_code_out));
  analog_side_model partner (.core_clk(core_clk), .reset_n(reset_n), .adc_tick(adc_tick),
    .conv_done(conv_done), .temp_internal(temp_internal), .temp_external(temp_external));

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 2 ns after the edge so the design never samples them mid-change
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    tick(1);
    reg_req = '0;
    if (a[7:3] == 5'h02) pend[a[2:0]] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    tick(1);
    reg_req = '0;
    check(reg_rdata, exp);
  endtask
  function automatic logic [47:0] model_out();
    for (int d = 0; d < 4; d++) model_out[12*d +: 12] = {live[2*d][7:0], live[2*d+1][7:4]};
  endfunction
  // Pin held low k cycles; a held-low pin must load only once
  task automatic pin_pulse(input int k, input bit takes);
    tick(1);
    load_outputs_strobe_n = 1'b0;
    tick(k);
    load_outputs_strobe_n = 1'b1;
    if (takes) live = pend;
    tick(2);
  endtask
  // Bounded wait for a result, counting readings on the way
  task automatic wait_rv(input int lim);
    n = 0;
    while (result_valid !== 1'b1 && n < lim) begin
      v += int'(conv_done === 1'b1);
      tick(1);
      n++;
    end
    if (n >= lim) failures++;
    tick(1);
  endtask
  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Calibration alone is 100000 cycles; the averaged results add about 30000
  initial begin
    repeat (180000) @(posedge core_clk);
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h2DA791F1));
    for (i = 0; i < 8; i++) begin
      live[i] = 0;
      pend[i] = 0;
    end
    tick(6);
    reset_n = 1'b1;
    wr(monitor_dac_pkg::CONTROL_ONE, 8'h01);
    n = 0;
    while (cal_done !== 1'b1 && n < 100100) begin
      tick(1);
      n++;
    end
    check(measuring, 1'b0);
    check(dac_code_out, 48'h0);
    rd(monitor_dac_pkg::STATUS_ADDR, 8'h02);
    $display("test calibration done");
    v = $urandom;
    wr(monitor_dac_pkg::DAC_SETUP, v[7:0] & 8'hCF);
    rd(monitor_dac_pkg::DAC_SETUP, v[7:0] & 8'hCF);
    check(analog_ctl.gain_two, v[3:0]);
    wr(monitor_dac_pkg::LOAD_SETUP, v[15:8]);
    rd(8'h3F, 8'h00);
    check(analog_ctl.int_ref, v[12]);
    $display("test setup registers done");
    for (i = 0; i < 8; i++) wr(8'h10 + 8'(i), 8'($urandom));
    check(dac_code_out, model_out());
    rd(8'h10, 8'h00);
    pin_pulse(3, 1'b1);
    for (i = 0; i < 8; i++) rd(8'h10 + 8'(i), live[i][7:0]);
    check(dac_code_out, model_out());
    load_outputs_strobe_n = 1'b0;
    wr(8'h12, 8'hA5);
    tick(2);
    check(dac_code_out, model_out());
    load_outputs_strobe_n = 1'b1;
    pin_pulse(1, 1'b1);
    check(dac_code_out, model_out());
    wr(monitor_dac_pkg::CONTROL_THREE, 8'h08);
    wr(8'h14, 8'h5A);
    pin_pulse(2, 1'b0);
    check(dac_code_out, model_out());
    for (i = 0; i < 3; i++) begin
      wr(8'h16, 8'($urandom));
      wr((i == 2) ? monitor_dac_pkg::LOAD_SETUP : monitor_dac_pkg::DAC_SETUP, 8'h10 << i);
      live = pend;
      tick(1);
      check(dac_code_out, model_out());
    end
    wr(monitor_dac_pkg::CONTROL_THREE, 8'h80);
    tick(1);
    check(dac_out_en, 1'b0);
    wr(monitor_dac_pkg::CONTROL_THREE, 8'h01);
    tick(1);
    check({analog_ctl.fast_clock, analog_ctl.filters_on, dac_out_en}, 3'b101);
    $display("test dac loading done");
    wr(monitor_dac_pkg::CONTROL_TWO, 8'h20);
    wr(monitor_dac_pkg::CONTROL_ONE, 8'h01);
    tick(1);
    check(measuring, 1'b1);
    ch_q = '{monitor_dac_pkg::CH_INTERNAL, monitor_dac_pkg::CH_EXTERNAL,
             monitor_dac_pkg::CH_SUPPLY};
    for (i = 0; i < 6; i++) begin
      wait_rv(2000);
      exp_ch = ch_q.pop_front();
      ch_q.push_back(exp_ch);
      check(channel, exp_ch);
    end
    for (i = 0; i < 3; i++) begin
      wr(monitor_dac_pkg::CONTROL_TWO, 8'h31 + 8'(i));
      wait_rv(2000);
      v = 0;
      wait_rv(2000);
      check(v, 1);
      check(channel, (i < 2) ? (3'b010 << i) : 3'b001);
      check(measuring, 1'b1);
    end
    wr(monitor_dac_pkg::CONTROL_TWO, 8'h00);
    wait_rv(16000);
    v = 0;
    wait_rv(16000);
    check(v, 16);
    wr(monitor_dac_pkg::CONTROL_ONE, 8'h00);
    tick(1);
    check(measuring, 1'b0);
    $display("test monitoring done");
    spi_select_req = 1'b1;
    tick(1);
    spi_select_req = 1'b0;
    tick(1);
    check(spi_locked, 1'b1);
    rd(monitor_dac_pkg::STATUS_ADDR, 8'h0A);
    reset_n = 1'b0;
    tick(6);
    reset_n = 1'b1;
    tick(1);
    check(spi_locked, 1'b0);
    $display("test serial lock done");
    complete_run();
  end
endmodule // monitor_and_dac_update_control_bench

// ===== dv/monitor_dac_checker_sva.sv
// Checker: port-level assertions for the monitor and DAC update control
`timescale 1ns/1ps
module monitor_dac_checker (
  input wire logic                          core_clk,
  input wire logic                          reset_n,
  input wire monitor_dac_pkg::reg_req_t     reg_req,
  input wire logic [7:0]                    reg_rdata,
  input wire logic                          spi_select_req,
  input wire logic                          load_outputs_strobe_n,
  input wire logic                          conv_done,
  input wire logic [11:0]                   temp_internal,
  input wire logic [11:0]                   temp_external,
  input wire logic                          spi_locked,
  input wire logic                          cal_done,
  input wire logic                          measuring,
  input wire monitor_dac_pkg::channel_t     channel,
  input wire logic                          result_valid,
  input wire logic                          adc_tick,
  input wire monitor_dac_pkg::analog_ctl_t  analog_ctl,
  input wire logic                          dac_out_en,
  input wire logic [47:0]                   dac_code_out
);
  wire logic   wr_ok = cal_done && reg_req.wr;
  logic [7:0]  ctl2, ctl3;
  logic [7:0]  pend [8];
  logic [47:0] exp_code;
  logic [4:0]  cnt;
  logic [15:0] gap;
  logic        cnt_ok, gap_ok;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Shadow of control writes, since mode bits decide what rr_order_a, avg_count_a, tick_gap_a and pin_load_a expect
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctl2 <= 8'h00;
      ctl3 <= 8'h00;
    end else if (wr_ok && reg_req.addr == monitor_dac_pkg::CONTROL_TWO) begin
      ctl2 <= reg_req.data;
    end else if (wr_ok && reg_req.addr == monitor_dac_pkg::CONTROL_THREE) begin
      ctl3 <= reg_req.data;
    end
  end

  // Pending code bytes as the host wrote them
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pend <= '{default: 8'h00};
    end else if (wr_ok && reg_req.addr[7:3] == 5'h02) begin
      pend[reg_req.addr[2:0]] <= reg_req.data;
    end
  end

  // Output word a load should produce
  always_comb begin
    for (int d = 0; d < 4; d++) exp_code[12*d +: 12] = {pend[2*d], pend[2*d+1][7:4]};
  end

  // Readings per result and tick spacing; any mode write voids the span under way
  always_ff @(posedge core_clk) begin
    if (!reset_n || !measuring || wr_ok) begin
      cnt    <= 5'h00;
      cnt_ok <= 1'b0;
      gap    <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      cnt    <= result_valid ? 5'(conv_done) : cnt + 5'(conv_done);
      cnt_ok <= cnt_ok | result_valid;
      gap    <= adc_tick ? 16'h0001 : gap + 16'h0001;
      gap_ok <= gap_ok | adc_tick;
    end
  end

  sequence pin_fall;
    load_outputs_strobe_n ##1 (!load_outputs_strobe_n && !ctl3[3]);
  endsequence
  sequence code_wr;
    wr_ok && reg_req.addr[7:3] == 5'h02 && load_outputs_strobe_n
      && $past(load_outputs_strobe_n) && $past(load_outputs_strobe_n, 2);
  endsequence

  idle_zero_a: assert property ($rose(cal_done) |-> dac_code_out == 48'h0 && !measuring)
    else $error("outputs not idle after calibration");
  run_bit_a: assert property (wr_ok && reg_req.addr == monitor_dac_pkg::CONTROL_ONE
    |-> ##2 measuring == $past(reg_req.data[0], 2)) else $error("run bit not followed");
  rr_order_a: assert property (measuring && $past(measuring) && !ctl2[4] && !$past(ctl2[4])
    && $changed(channel) |-> channel == {$past(channel[1:0]), $past(channel[2])})
    else $error("round robin order broken");
  avg_count_a: assert property (result_valid && cnt_ok |-> cnt == (ctl2[5] ? 5'h01 : 5'h10))
    else $error("wrong reading count per result");
  tick_gap_a: assert property (adc_tick && gap_ok
    |-> gap == (ctl3[0] ? 16'(monitor_dac_pkg::FAST_DIV) : 16'(monitor_dac_pkg::SLOW_DIV)))
    else $error("conversion clock period wrong");
  ctl_three_a: assert property (wr_ok && reg_req.addr == monitor_dac_pkg::CONTROL_THREE
    |-> ##2 analog_ctl.fast_clock == $past(reg_req.data[0], 2)
    && analog_ctl.filters_on != $past(reg_req.data[0], 2)
    && dac_out_en != $past(reg_req.data[7], 2)) else $error("control three fields not applied");
  setup_bits_a: assert property (wr_ok && reg_req.addr == monitor_dac_pkg::DAC_SETUP
    |-> ##2 analog_ctl.gain_two == $past(reg_req.data[3:0], 2)
    && analog_ctl.buf_ab == $past(reg_req.data[6], 2)
    && analog_ctl.buf_cd == $past(reg_req.data[7], 2)) else $error("dac setup fields not applied");
  ref_sel_a: assert property (wr_ok && reg_req.addr == monitor_dac_pkg::LOAD_SETUP
    |-> ##2 analog_ctl.int_ref == $past(reg_req.data[4], 2))
    else $error("reference select not applied");
  pin_load_a: assert property (pin_fall |-> ##2 dac_code_out == $past(exp_code, 2))
    else $error("pin load did not move codes");
  code_hold_a: assert property (code_wr |=> $stable(dac_code_out) [*2])
    else $error("code reached output without load");
  spi_lock_a: assert property (spi_select_req || spi_locked |=> spi_locked)
    else $error("serial mode lock lost");
endmodule // monitor_dac_checker

bind monitor_and_dac_update_control monitor_dac_checker chk (.core_clk(core_clk),
  .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .spi_select_req(spi_select_req),
  .load_outputs_strobe_n(load_outputs_strobe_n), .conv_done(conv_done),
  .temp_internal(temp_internal), .temp_external(temp_external), .spi_locked(spi_locked),
  .cal_done(cal_done), .measuring(measuring), .channel(channel), .result_valid(result_valid),
  .adc_tick(adc_tick), .analog_ctl(analog_ctl), .dac_out_en(dac_out_en),
  .dac_code_out(dac_code_out));

// ===== hw/monitor_and_dac_update_control.sv
// Monitor sequencing, DAC double buffering and serial mode lock for the sensor/DAC device
//
// Notes on behaviour
// - After calibration, idle: powered, no measurement, all DAC outputs at zero.
// - Writing run bit one in control_one starts round-robin monitoring.
// - Round robin order supply, internal, external, then straight back to supply.
// - Monitoring loops until the run bit is cleared.
// - Single-channel bit in control_two switches to single-channel, monitoring continues.
// - Averaging on from reset; each result averages sixteen readings.
// - Averaging-disable bit makes each result one reading.
// - Fast-clock bit selects fast ADC clock and turns external filters off.
// - DAC codes written through MSB/LSB registers at 0x10 to 0x17.
// - Load pin updates outputs by default; load-source bit hands control to registers.
// - Setup registers select gain, reference buffers and internal or external reference.
// - Written codes wait in a buffer until a load command.
// - Code register reads return the code driving the output.
// - Loads come from pin falling edge, setup trigger bits, or load_setup.
// - Once SPI is selected it locks; I2C never locks.
// - Interface starts in I2C; leaves SPI only on power cycle.
// - Straight binary codes, full scale 255, 1023 or 4095.
// - Power-down turns DACs off with high-impedance outputs.
// - When configured DAC A shows internal, DAC B external temperature for one cycle after each result on that channel.
// - Low four dac_setup bits select gain two per DAC.
// - load_setup internal-reference bit picks on-chip reference; default external.
`timescale 1ns/1ps
module monitor_and_dac_update_control (
  input  wire logic                                  core_clk,
  input  wire logic                                  reset_n,
  input  wire monitor_dac_pkg::reg_req_t             reg_req,
  output logic [7:0]                                 reg_rdata,
  input  wire logic                                  spi_select_req,
  input  wire logic                                  load_outputs_strobe_n,
  input  wire logic                                  conv_done,
  input  wire logic [monitor_dac_pkg::DAC_BITS-1:0]  temp_internal,
  input  wire logic [monitor_dac_pkg::DAC_BITS-1:0]  temp_external,
  output logic                                       spi_locked,
  output logic                                       cal_done,
  output logic                                       measuring,
  output monitor_dac_pkg::channel_t                  channel,
  output logic                                       result_valid,
  output logic                                       adc_tick,
  output monitor_dac_pkg::analog_ctl_t               analog_ctl,
  output logic                                       dac_out_en,
  output logic [4*monitor_dac_pkg::DAC_BITS-1:0]     dac_code_out
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] control_three;
  logic [7:0] dac_setup;
  logic [7:0] load_setup;
  logic [7:0] pend_code [8];   // Buffered MSB/LSB bytes
  logic [7:0] live_code [8];   // Bytes driving the outputs
  logic       strobe_q;
  logic       pin_load;
  logic       sw_load;
  logic       do_load;
  logic [31:0] cal_cnt;
  logic [15:0] div_cnt;
  logic [4:0]  avg_cnt;
  monitor_dac_pkg::mon_state_t state;
  monitor_dac_pkg::channel_t   result_ch; // Channel whose result just finished

  // Address falls inside the code byte window
  function automatic logic is_code(input logic [7:0] a);
    return a >= monitor_dac_pkg::DAC_CODE_FIRST && a <= monitor_dac_pkg::DAC_CODE_LAST;
  endfunction

  function automatic logic [2:0] code_idx(input logic [7:0] a);
    return 3'(a - monitor_dac_pkg::DAC_CODE_FIRST);
  endfunction

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control_one   <= monitor_dac_pkg::REG_RESET;
      control_two   <= monitor_dac_pkg::REG_RESET; // Averaging on, round robin
      control_three <= monitor_dac_pkg::REG_RESET; // Slow clock, pin load
      dac_setup     <= monitor_dac_pkg::REG_RESET;
      load_setup    <= monitor_dac_pkg::REG_RESET; // External reference
    end else if (reg_req.wr && cal_done) begin
      unique case (reg_req.addr)
        monitor_dac_pkg::CONTROL_ONE:   control_one   <= reg_req.data;
        monitor_dac_pkg::CONTROL_TWO:   control_two   <= reg_req.data;
        monitor_dac_pkg::CONTROL_THREE: control_three <= reg_req.data;
        monitor_dac_pkg::DAC_SETUP:     dac_setup     <= reg_req.data;
        monitor_dac_pkg::LOAD_SETUP:    load_setup    <= reg_req.data;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Code buffers and load commands
  // ------------------------------------------------------------------
  // Pin falling edge only counts while the pin owns updating; a held low never reloads
  assign pin_load = strobe_q && !load_outputs_strobe_n
                    && !control_three[monitor_dac_pkg::LOAD_SRC_BIT];
  // Software load while the load-source bit is set: writing setup with a trigger bit, or any write to load_setup
  assign sw_load  = control_three[monitor_dac_pkg::LOAD_SRC_BIT] && reg_req.wr && cal_done
                    && ((reg_req.addr == monitor_dac_pkg::DAC_SETUP
                         && (reg_req.data[monitor_dac_pkg::TRIG_A_BIT]
                             || reg_req.data[monitor_dac_pkg::TRIG_B_BIT]))
                        || reg_req.addr == monitor_dac_pkg::LOAD_SETUP);
  assign do_load  = pin_load || sw_load;

  always_ff @(posedge core_clk) begin
    if (!reset_n) strobe_q <= 1'b1;
    else          strobe_q <= load_outputs_strobe_n;
  end

  generate
    for (genvar i = 0; i < 8; i++) begin : g_code
      // A write in the load cycle lands in the buffer; the load moves the older value
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pend_code[i] <= monitor_dac_pkg::REG_RESET;
          live_code[i] <= monitor_dac_pkg::REG_RESET; // Zero code at power-up
        end else begin
          if (reg_req.wr && cal_done && is_code(reg_req.addr) && code_idx(reg_req.addr) == i)
            pend_code[i] <= reg_req.data;
          if (do_load)
            live_code[i] <= pend_code[i];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Calibration and monitoring sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cal_cnt <= '0;
      state   <= monitor_dac_pkg::ST_CAL;
    end else begin
      unique case (state)
        monitor_dac_pkg::ST_CAL: begin
          cal_cnt <= cal_cnt + 32'd1;
          if (cal_cnt == 32'(monitor_dac_pkg::CAL_CYCLES - 1))
            state <= monitor_dac_pkg::ST_IDLE;
        end
        monitor_dac_pkg::ST_IDLE:
          if (control_one[monitor_dac_pkg::RUN_BIT]) state <= monitor_dac_pkg::ST_RUN;
        monitor_dac_pkg::ST_RUN:
          if (!control_one[monitor_dac_pkg::RUN_BIT]) state <= monitor_dac_pkg::ST_IDLE;
        default: state <= monitor_dac_pkg::ST_IDLE;
      endcase
    end
  end

  // ADC clock divider, slow by default
  always_ff @(posedge core_clk) begin
    if (!reset_n || state != monitor_dac_pkg::ST_RUN) begin
      div_cnt  <= '0;
      adc_tick <= 1'b0;
    end else if (div_cnt == (control_three[monitor_dac_pkg::FAST_CLK_BIT]
                             ? 16'(monitor_dac_pkg::FAST_DIV - 1)
                             : 16'(monitor_dac_pkg::SLOW_DIV - 1))) begin
      div_cnt  <= '0;
      adc_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 16'd1;
      adc_tick <= 1'b0;
    end
  end

  // Channel advance after each finished result
  always_ff @(posedge core_clk) begin
    if (!reset_n || state != monitor_dac_pkg::ST_RUN) begin
      channel      <= monitor_dac_pkg::CH_SUPPLY; // Round robin restarts at supply
      result_ch    <= monitor_dac_pkg::CH_SUPPLY;
      avg_cnt      <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (control_two[monitor_dac_pkg::SINGLE_CH_BIT]) begin
        unique case (control_two[monitor_dac_pkg::CH_SEL_LO +: 2])
          2'h1:    channel <= monitor_dac_pkg::CH_INTERNAL;
          2'h2:    channel <= monitor_dac_pkg::CH_EXTERNAL;
          default: channel <= monitor_dac_pkg::CH_SUPPLY;
        endcase
      end
      if (conv_done) begin
        if (control_two[monitor_dac_pkg::AVG_DISABLE_BIT]
            || avg_cnt == monitor_dac_pkg::AVG_LAST) begin
          avg_cnt      <= '0;
          result_valid <= 1'b1;
          result_ch    <= channel; // Channel moves on at this edge
          if (!control_two[monitor_dac_pkg::SINGLE_CH_BIT]) begin
            unique case (channel)
              monitor_dac_pkg::CH_SUPPLY:   channel <= monitor_dac_pkg::CH_INTERNAL;
              monitor_dac_pkg::CH_INTERNAL: channel <= monitor_dac_pkg::CH_EXTERNAL;
              default:                      channel <= monitor_dac_pkg::CH_SUPPLY;
            endcase
          end
        end else begin
          avg_cnt <= avg_cnt + 5'd1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Serial mode lock: only a power cycle (reset) returns to I2C
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n)            spi_locked <= 1'b0;
    else if (spi_select_req) spi_locked <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Read data and outputs
  // ------------------------------------------------------------------
  // Code reads see the live bytes, never the buffer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= monitor_dac_pkg::REG_RESET;
    end else if (reg_req.rd) begin
      if (is_code(reg_req.addr))
        reg_rdata <= live_code[code_idx(reg_req.addr)];
      else unique case (reg_req.addr)
        monitor_dac_pkg::CONTROL_ONE:   reg_rdata <= control_one;
        monitor_dac_pkg::CONTROL_TWO:   reg_rdata <= control_two;
        monitor_dac_pkg::CONTROL_THREE: reg_rdata <= control_three;
        monitor_dac_pkg::DAC_SETUP:     reg_rdata <= dac_setup;
        monitor_dac_pkg::LOAD_SETUP:    reg_rdata <= load_setup;
        monitor_dac_pkg::STATUS_ADDR:
          reg_rdata <= {4'h0, spi_locked, (state == monitor_dac_pkg::ST_RUN), cal_done, 1'b0};
        default:                        reg_rdata <= monitor_dac_pkg::REG_RESET;
      endcase
    end
  end

  assign cal_done = state != monitor_dac_pkg::ST_CAL;
  assign measuring = state == monitor_dac_pkg::ST_RUN;

  // Straight binary 12-bit codes: MSB byte high, LSB high nibble low; narrower parts ignore LSBs
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dac_code_out <= '0;
    end else begin
      for (int d = 0; d < monitor_dac_pkg::NUM_DACS; d++)
        dac_code_out[d*12 +: 12] <= {live_code[2*d], live_code[2*d+1][7:4]};
      if (control_three[monitor_dac_pkg::TRACK_INT_BIT] && result_valid
          && result_ch == monitor_dac_pkg::CH_INTERNAL)
        dac_code_out[0 +: 12] <= temp_internal;
      if (control_three[monitor_dac_pkg::TRACK_EXT_BIT] && result_valid
          && result_ch == monitor_dac_pkg::CH_EXTERNAL)
        dac_code_out[12 +: 12] <= temp_external;
    end
  end

  // Analog controls are registered so they never glitch into the reference switches
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      analog_ctl <= '{filters_on: 1'b1, default: '0}; // Slow clock keeps filters on
      dac_out_en <= 1'b1;
    end else begin
      analog_ctl.gain_two   <= dac_setup[3:0];
      analog_ctl.buf_ab     <= dac_setup[monitor_dac_pkg::BUF_AB_BIT];
      analog_ctl.buf_cd     <= dac_setup[monitor_dac_pkg::BUF_CD_BIT];
      analog_ctl.int_ref    <= load_setup[monitor_dac_pkg::INT_REF_BIT];
      analog_ctl.power_down <= control_three[monitor_dac_pkg::PWR_DOWN_BIT];
      analog_ctl.fast_clock <= control_three[monitor_dac_pkg::FAST_CLK_BIT];
      analog_ctl.filters_on <= !control_three[monitor_dac_pkg::FAST_CLK_BIT];
      dac_out_en            <= !control_three[monitor_dac_pkg::PWR_DOWN_BIT];
    end
  end

endmodule // monitor_and_dac_update_control

// ===== inc/monitor_dac_pkg.sv
// Package: register map, field positions and timing constants for the monitor and DAC control
package monitor_dac_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] DAC_CODE_FIRST = 8'h10; // Per-channel MSB/LSB pairs
  localparam logic [7:0] DAC_CODE_LAST  = 8'h17;
  localparam logic [7:0] CONTROL_ONE    = 8'h18;
  localparam logic [7:0] CONTROL_TWO    = 8'h19;
  localparam logic [7:0] CONTROL_THREE  = 8'h1A;
  localparam logic [7:0] DAC_SETUP      = 8'h1B;
  localparam logic [7:0] LOAD_SETUP     = 8'h1C;
  localparam logic [7:0] STATUS_ADDR    = 8'h1D;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int RUN_BIT         = 0; // control_one
  localparam int SINGLE_CH_BIT   = 4; // control_two
  localparam int AVG_DISABLE_BIT = 5;
  localparam int CH_SEL_LO       = 0;
  localparam int FAST_CLK_BIT    = 0; // control_three
  localparam int LOAD_SRC_BIT    = 3;
  localparam int PWR_DOWN_BIT    = 7;
  localparam int TRACK_INT_BIT   = 5;
  localparam int TRACK_EXT_BIT   = 6;
  localparam int TRIG_A_BIT      = 4; // dac_setup
  localparam int TRIG_B_BIT      = 5;
  localparam int BUF_AB_BIT      = 6;
  localparam int BUF_CD_BIT      = 7;
  localparam int INT_REF_BIT     = 4; // load_setup
  localparam int LOAD_SW_MASK_LO = 0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] AVG_LAST  = 5'h0F; // Sixteen readings per result
  localparam int         DAC_BITS  = 12;
  localparam int         NUM_DACS  = 4;

  // ------------------------------------------------------------------
  // Timing (20 MHz core clock)
  // ------------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int CAL_TIME_US   = 5000;
  localparam int CAL_CYCLES    = CLK_HZ / 1_000_000 * CAL_TIME_US;
  localparam int SLOW_ADC_HZ   = 1400;
  localparam int FAST_ADC_HZ   = 22000;
  localparam int SLOW_DIV      = CLK_HZ / SLOW_ADC_HZ;
  localparam int FAST_DIV      = CLK_HZ / FAST_ADC_HZ;

  typedef enum logic [2:0] {
    CH_SUPPLY   = 3'b001,
    CH_INTERNAL = 3'b010,
    CH_EXTERNAL = 3'b100
  } channel_t;

  typedef enum logic [2:0] {
    ST_CAL  = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN  = 3'b100
  } mon_state_t;

  // Register read or write request from the serial front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  // Analog-side controls
  typedef struct packed {
    logic [3:0] gain_two;
    logic       buf_ab;
    logic       buf_cd;
    logic       int_ref;
    logic       power_down;
    logic       fast_clock;
    logic       filters_on;
  } analog_ctl_t;

endpackage
